// file: src/drc_params.svh
// Register addresses, field positions, reset values and divider defaults
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH

`define DRC_ADDR_SEC   5'h00
`define DRC_ADDR_MIN   5'h01
`define DRC_ADDR_HR    5'h02
`define DRC_ADDR_WDAY  5'h03
`define DRC_ADDR_DATE  5'h04
`define DRC_ADDR_MON   5'h05
`define DRC_ADDR_YEAR  5'h06
`define DRC_ADDR_CTRL  5'h0e
`define DRC_ADDR_SRAM  5'h10
`define DRC_ADDR_LAST  5'h1f
`define DRC_TIME_REGS  7
`define DRC_MEM_LO     7
`define DRC_MEM_HI     31

`define DRC_RST_SEC    8'h00
`define DRC_RST_MIN    8'h00
`define DRC_RST_HR     8'h00
`define DRC_RST_WDAY   8'h01
`define DRC_RST_DATE   8'h01
`define DRC_RST_MON    8'h01
`define DRC_RST_YEAR   8'h00
`define DRC_RST_CTRL   8'h84

`define DRC_CTRL_ENA   7
`define DRC_CTRL_SEL1  6
`define DRC_CTRL_SEL0  5
`define DRC_CTRL_INTCN 2
`define DRC_HR_MODE    5
`define DRC_HR_12H     6
`define DRC_MON_CENT   7

`define DRC_SEC_MAX    8'h59
`define DRC_MIN_MAX    8'h59
`define DRC_HR24_MAX   6'h23
`define DRC_HR12_MAX   5'h12
`define DRC_HR12_PRE   5'h11
`define DRC_MON_MAX    5'h12
`define DRC_YEAR_MAX   8'h99
`define DRC_WDAY_MAX   8'h07

`define DRC_DIV_32K    32768
`define DRC_DIV_8K     8192
`define DRC_DIV_60     60
`define DRC_DIV_50     50
`define DRC_DEV_ADDR   7'h5a

`endif

// file: src/drc_pkg.sv
// Shared types of the digital input clock/calendar
package drc_pkg;
  typedef logic [7:0] drc_byte_t;
  typedef logic [4:0] drc_ptr_t;
  typedef enum {
    DRC_IDLE, DRC_ADDR, DRC_ADDR_ACK, DRC_PTR, DRC_PTR_ACK,
    DRC_WR, DRC_WR_ACK, DRC_RD, DRC_RD_ACK
  } drc_link_e;
endpackage : drc_pkg

// file: src/drc_i2c_link.sv
// Two-wire slave running on the serial clock
`timescale 1ns/1ps
`default_nettype none
`include "drc_params.svh"
module drc_i2c_link #(
  parameter logic [6:0] DEV_ADDR = `DRC_DEV_ADDR
) (
  input  wire logic        scl,
  input  wire logic        arst_n,
  input  wire logic        sda_in,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             start_tog,
  output logic             stop_tog,
  output logic             wrap_tog,
  output logic             wr_tog,
  output logic             rd_tog,
  output drc_pkg::drc_ptr_t  wr_addr,
  output drc_pkg::drc_byte_t wr_data,
  output drc_pkg::drc_ptr_t  rd_addr,
  input  wire drc_pkg::drc_byte_t rd_data
);
  import drc_pkg::*;

  drc_link_e st_r;
  logic [2:0] bitc_r;
  logic [6:0] sh_r;
  logic       start_seen_r;
  drc_ptr_t   ptr_r;
  drc_byte_t  byte_in;

  function automatic drc_ptr_t ptr_inc(input drc_ptr_t p);
    return (p == `DRC_ADDR_LAST) ? '0 : p + 5'h01;
  endfunction : ptr_inc

  assign byte_in = {sh_r, sda_in};
  assign rd_addr = ptr_r;
  assign sda_o   = 1'b0;

  // ------------------------------------------------------------
  // START and STOP detection on data edges
  // ------------------------------------------------------------
  always_ff @(negedge sda_in or negedge arst_n) begin
    if (!arst_n) begin
      start_tog <= 1'b0;
    end else if (scl) begin
      start_tog <= ~start_tog;
    end
  end

  always_ff @(posedge sda_in or negedge arst_n) begin
    if (!arst_n) begin
      stop_tog <= 1'b0;
    end else if (scl) begin
      stop_tog <= ~stop_tog;
    end
  end

  // ------------------------------------------------------------
  // Bit sampling and byte sequencing
  // ------------------------------------------------------------
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= DRC_IDLE;
      bitc_r <= '0;
      sh_r <= '0;
      start_seen_r <= 1'b0;
      ptr_r <= '0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_tog <= 1'b0;
      rd_tog <= 1'b0;
      wrap_tog <= 1'b0;
    end else if (start_tog != start_seen_r) begin
      start_seen_r <= start_tog;
      st_r <= DRC_ADDR;
      sh_r <= {6'h00, sda_in};
      bitc_r <= 3'h1;
    end else begin
      sh_r <= byte_in[6:0];
      bitc_r <= bitc_r + 3'h1;
      case (st_r)
        DRC_ADDR: begin
          if (bitc_r == 3'h7) begin
            if (byte_in[7:1] == DEV_ADDR) begin
              st_r <= DRC_ADDR_ACK;
              if (byte_in[0]) begin
                rd_tog <= ~rd_tog;
              end
            end else begin
              st_r <= DRC_IDLE;
            end
          end
        end
        DRC_ADDR_ACK: begin
          bitc_r <= '0;
          st_r <= sh_r[0] ? DRC_RD : DRC_PTR;
        end
        DRC_PTR: begin
          if (bitc_r == 3'h7) begin
            ptr_r <= byte_in[4:0];
            st_r <= DRC_PTR_ACK;
          end
        end
        DRC_PTR_ACK, DRC_WR_ACK: begin
          bitc_r <= '0;
          st_r <= DRC_WR;
        end
        DRC_WR: begin
          if (bitc_r == 3'h7) begin
            wr_data <= byte_in;
            wr_addr <= ptr_r;
            wr_tog <= ~wr_tog;
            ptr_r <= ptr_inc(ptr_r);
            if (ptr_r == `DRC_ADDR_LAST) begin
              wrap_tog <= ~wrap_tog;
            end
            st_r <= DRC_WR_ACK;
          end
        end
        DRC_RD: begin
          if (bitc_r == 3'h7) begin
            st_r <= DRC_RD_ACK;
          end
        end
        DRC_RD_ACK: begin
          bitc_r <= '0;
          ptr_r <= ptr_inc(ptr_r);
          if (ptr_r == `DRC_ADDR_LAST) begin
            wrap_tog <= ~wrap_tog;
          end
          rd_tog <= ~rd_tog;
          st_r <= sda_in ? DRC_IDLE : DRC_RD;
        end
        default: begin
          st_r <= DRC_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Data line drive on falling clock
  // ------------------------------------------------------------
  always_ff @(negedge scl or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe <= 1'b0;
    end else begin
      case (st_r)
        DRC_ADDR_ACK, DRC_PTR_ACK, DRC_WR_ACK: sda_oe <= 1'b1;
        DRC_RD: sda_oe <= ~rd_data[3'h7 - bitc_r];
        default: sda_oe <= 1'b0;
      endcase
    end
  end

  ptr_wrap_a: assert property (@(posedge scl) disable iff (!arst_n)
    (st_r == DRC_RD_ACK && ptr_r == `DRC_ADDR_LAST && start_tog == start_seen_r)
    |=> ptr_r == '0)
    else $error("pointer did not wrap");

  addr_miss_a: assert property (@(posedge scl) disable iff (!arst_n)
    (st_r == DRC_ADDR && bitc_r == 3'h7 && byte_in[7:1] != DEV_ADDR
     && start_tog == start_seen_r) |=> st_r == DRC_IDLE)
    else $error("foreign address accepted");

  wr_adv_a: assert property (@(posedge scl) disable iff (!arst_n)
    (st_r == DRC_WR && bitc_r == 3'h7 && start_tog == start_seen_r)
    |=> ptr_r == ptr_inc(wr_addr) && wr_addr == $past(ptr_r))
    else $error("pointer did not advance on write");
endmodule : drc_i2c_link
`default_nettype wire

// file: src/drc_rtc_top.sv
// Clock/calendar core with timebase divider, read buffer and storage
// Behaviour
// - Seconds through years count from the timebase while ce and control bit 7 are high.
// - Date rolls at month end by month length and leap year.
// - Hours run in 24-hour or 12-hour count with afternoon flag.
// - Power-up sets 01/01/00, weekday 01, 00:00:00.
// - Sixteen bytes of user storage reachable over the serial bus.
// - Access opens with START and device address; a write then sends a pointer byte before data bytes, a read returns data bytes.
// - Further bytes address the next register; STOP keeps the link state, START restarts it.
// - Square-wave output only pulls low, never drives high.
// - Pointer advances per byte and wraps from last to zero.
// - START, STOP and wrap copy running time into the read buffer.
// - All time and calendar values are held in BCD.
// - Hours bit 6 selects 12-hour; bit 5 is afternoon or twenty.
`timescale 1ns/1ps
`default_nettype none
`include "drc_params.svh"
module drc_rtc_top #(
  parameter logic [15:0] DIV_32K  = 16'(`DRC_DIV_32K),
  parameter logic [15:0] DIV_8K   = 16'(`DRC_DIV_8K),
  parameter logic [15:0] DIV_60   = 16'(`DRC_DIV_60),
  parameter logic [15:0] DIV_50   = 16'(`DRC_DIV_50),
  parameter logic [6:0]  DEV_ADDR = `DRC_DEV_ADDR
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  input  wire logic tb_clk_in,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_o,
  output logic      sda_oe,
  output logic      sqw_o,
  output logic      sqw_oe
);
  import drc_pkg::*;

  if (DIV_32K < 16'h2 || DIV_8K < 16'h2 || DIV_60 < 16'h2 || DIV_50 < 16'h2) begin : g_chk
    $error("timebase divisors must be at least 2");
  end

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic       start_tog, stop_tog, wrap_tog, wr_tog, rd_tog;
  drc_ptr_t   wr_addr, rd_addr;
  drc_byte_t  wr_data, rd_data_r;
  logic [4:0] tg_s1_r, tg_s2_r, tg_s3_r, tg_evt;
  logic       start_evt, stop_evt, wrap_evt, wr_evt, rd_evt, snap_evt;
  logic       tb_s1_r, tb_s2_r, tb_prev_r, tb_rise;
  logic [15:0] pre_cnt_r, div, div_m1;
  logic       ena, tick, sec_wr, time_wr;
  drc_byte_t  sec_r, min_r, hr_r, wday_r, date_r, mon_r, year_r;
  drc_byte_t  sec_nxt, min_nxt, hr_nxt, wday_nxt, date_nxt, mon_nxt, year_nxt;
  drc_byte_t  live [0:`DRC_TIME_REGS-1];
  drc_byte_t  snap_r [0:`DRC_TIME_REGS-1];
  drc_byte_t  mem_r [`DRC_MEM_LO:`DRC_MEM_HI];

  // ------------------------------------------------------------
  // BCD helpers
  // ------------------------------------------------------------
  // BCD digit step
  function automatic drc_byte_t bcd_inc(input drc_byte_t v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic drc_byte_t month_len(input drc_byte_t m, input drc_byte_t y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m[4:0])
      5'h02: return leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : month_len

  function automatic drc_byte_t hour_inc(input drc_byte_t h);
    drc_byte_t v;
    v = '0;
    if (h[`DRC_HR_12H]) begin
      v = bcd_inc({3'h0, h[4:0]});
      if (h[4:0] == `DRC_HR12_MAX) begin
        v = 8'h01;
      end
      return {2'b01, h[`DRC_HR_MODE] ^ (h[4:0] == `DRC_HR12_PRE), v[4:0]};
    end
    v = (h[5:0] == `DRC_HR24_MAX) ? 8'h00 : bcd_inc({2'h0, h[5:0]});
    return {2'b00, v[5:0]};
  endfunction : hour_inc

  function automatic logic day_end(input drc_byte_t h);
    return h[`DRC_HR_12H] ? (h[`DRC_HR_MODE] && h[4:0] == `DRC_HR12_PRE)
                          : (h[5:0] == `DRC_HR24_MAX);
  endfunction : day_end

  // ------------------------------------------------------------
  // Serial link
  // ------------------------------------------------------------
  drc_i2c_link #(.DEV_ADDR(DEV_ADDR)) u_link (
    .scl       (scl),
    .arst_n    (arst_n),
    .sda_in    (sda_in),
    .sda_o     (sda_o),
    .sda_oe    (sda_oe),
    .start_tog (start_tog),
    .stop_tog  (stop_tog),
    .wrap_tog  (wrap_tog),
    .wr_tog    (wr_tog),
    .rd_tog    (rd_tog),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data_r)
  );

  // ------------------------------------------------------------
  // Event crossing from the link
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tg_s1_r <= '0;
      tg_s2_r <= '0;
      tg_s3_r <= '0;
    end else if (ce) begin
      tg_s1_r <= {rd_tog, wr_tog, wrap_tog, stop_tog, start_tog};
      tg_s2_r <= tg_s1_r;
      tg_s3_r <= tg_s2_r;
    end
  end

  assign tg_evt    = (tg_s2_r ^ tg_s3_r) & {5{ce}};
  assign start_evt = tg_evt[0];
  assign stop_evt  = tg_evt[1];
  assign wrap_evt  = tg_evt[2];
  assign wr_evt    = tg_evt[3];
  assign rd_evt    = tg_evt[4];
  assign snap_evt  = start_evt | stop_evt | wrap_evt;
  assign time_wr   = wr_evt && wr_addr < 5'(`DRC_TIME_REGS);
  assign sec_wr    = wr_evt && wr_addr == `DRC_ADDR_SEC;

  // ------------------------------------------------------------
  // Timebase divider
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tb_s1_r <= 1'b0;
      tb_s2_r <= 1'b0;
      tb_prev_r <= 1'b0;
    end else if (ce) begin
      tb_s1_r <= tb_clk_in;
      tb_s2_r <= tb_s1_r;
      tb_prev_r <= tb_s2_r;
    end
  end

  assign tb_rise = tb_s2_r & ~tb_prev_r;
  assign ena     = mem_r[`DRC_ADDR_CTRL][`DRC_CTRL_ENA];

  always_comb begin
    case ({mem_r[`DRC_ADDR_CTRL][`DRC_CTRL_SEL1], mem_r[`DRC_ADDR_CTRL][`DRC_CTRL_SEL0]})
      2'h0: div = DIV_32K;
      2'h1: div = DIV_8K;
      2'h2: div = DIV_60;
      default: div = DIV_50;
    endcase
  end

  assign div_m1 = div - 16'h1;
  assign tick   = ena && tb_rise && pre_cnt_r >= div_m1 && !time_wr;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt_r <= '0;
    end else if (ce) begin
      if (sec_wr) begin
        pre_cnt_r <= '0;
      end else if (ena && tb_rise) begin
        pre_cnt_r <= (pre_cnt_r >= div_m1) ? '0 : pre_cnt_r + 16'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Calendar cascade
  // ------------------------------------------------------------
  always_comb begin
    sec_nxt = sec_r;
    min_nxt = min_r;
    hr_nxt = hr_r;
    wday_nxt = wday_r;
    date_nxt = date_r;
    mon_nxt = mon_r;
    year_nxt = year_r;
    if (tick) begin
      sec_nxt = bcd_inc(sec_r);
      if (sec_r == `DRC_SEC_MAX) begin
        sec_nxt = '0;
        min_nxt = bcd_inc(min_r);
        if (min_r == `DRC_MIN_MAX) begin
          min_nxt = '0;
          hr_nxt = hour_inc(hr_r);
          if (day_end(hr_r)) begin
            wday_nxt = (wday_r == `DRC_WDAY_MAX) ? `DRC_RST_WDAY : bcd_inc(wday_r);
            date_nxt = bcd_inc(date_r);
            if (date_r == month_len(mon_r, year_r)) begin
              date_nxt = `DRC_RST_DATE;
              mon_nxt = bcd_inc({3'h0, mon_r[4:0]});
              mon_nxt[7:5] = mon_r[7:5];
              if (mon_r[4:0] == `DRC_MON_MAX) begin
                mon_nxt = `DRC_RST_MON;
                mon_nxt[7:5] = mon_r[7:5];
                year_nxt = bcd_inc(year_r);
                if (year_r == `DRC_YEAR_MAX) begin
                  year_nxt = '0;
                  mon_nxt[`DRC_MON_CENT] = ~mon_r[`DRC_MON_CENT];
                end
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_r <= `DRC_RST_SEC;
      min_r <= `DRC_RST_MIN;
      hr_r <= `DRC_RST_HR;
      wday_r <= `DRC_RST_WDAY;
      date_r <= `DRC_RST_DATE;
      mon_r <= `DRC_RST_MON;
      year_r <= `DRC_RST_YEAR;
    end else if (ce) begin
      if (time_wr) begin
        case (wr_addr)
          `DRC_ADDR_SEC: sec_r <= wr_data;
          `DRC_ADDR_MIN: min_r <= wr_data;
          `DRC_ADDR_HR: hr_r <= wr_data;
          `DRC_ADDR_WDAY: wday_r <= wr_data;
          `DRC_ADDR_DATE: date_r <= wr_data;
          `DRC_ADDR_MON: mon_r <= wr_data;
          default: year_r <= wr_data;
        endcase
      end else begin
        sec_r <= sec_nxt;
        min_r <= min_nxt;
        hr_r <= hr_nxt;
        wday_r <= wday_nxt;
        date_r <= date_nxt;
        mon_r <= mon_nxt;
        year_r <= year_nxt;
      end
    end
  end

  // ------------------------------------------------------------
  // Read buffer, storage and read answer
  // ------------------------------------------------------------
  assign live = '{sec_r, min_r, hr_r, wday_r, date_r, mon_r, year_r};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `DRC_TIME_REGS; i++) begin
        snap_r[i] <= '0;
      end
    end else if (snap_evt) begin
      snap_r <= live;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = `DRC_MEM_LO; i <= `DRC_MEM_HI; i++) begin
        mem_r[i] <= (i == int'(`DRC_ADDR_CTRL)) ? `DRC_RST_CTRL : '0;
      end
    end else if (wr_evt && !time_wr) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= '0;
    end else if (rd_evt) begin
      // Time reads come from the buffer, or from live time when a snapshot is taken in the same cycle
      if (rd_addr < 5'(`DRC_TIME_REGS)) begin
        rd_data_r <= snap_evt ? live[rd_addr[2:0]] : snap_r[rd_addr[2:0]];
      end else begin
        rd_data_r <= mem_r[rd_addr];
      end
    end
  end

  // ------------------------------------------------------------
  // Square-wave output
  // ------------------------------------------------------------
  assign sqw_o = 1'b0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sqw_oe <= 1'b0;
    end else if (ce) begin
      sqw_oe <= ena && !mem_r[`DRC_ADDR_CTRL][`DRC_CTRL_INTCN] && pre_cnt_r < (div >> 1);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence sec_write_s;
    ce && sec_wr;
  endsequence

  sequence snap_s;
    snap_evt;
  endsequence

  sqw_pull_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && (!ena || mem_r[`DRC_ADDR_CTRL][`DRC_CTRL_INTCN])) |=> !sqw_oe && !sqw_o)
    else $error("square-wave output driven while disabled");

  sec_bcd_a: assert property (@(posedge clk) disable iff (!arst_n)
    sec_r[3:0] <= 4'h9 && sec_r <= `DRC_SEC_MAX && min_r <= `DRC_MIN_MAX)
    else $error("seconds or minutes not BCD");

  tick_adv_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && tick) |=> sec_r == bcd_inc($past(sec_r)) || sec_r == '0)
    else $error("tick did not advance seconds");

  date_lim_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && tick && date_r == month_len(mon_r, year_r) && min_r == `DRC_MIN_MAX
     && sec_r == `DRC_SEC_MAX && day_end(hr_r)) |=> date_r == `DRC_RST_DATE)
    else $error("month end did not roll date");

  hour_fmt_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && tick && !hr_r[`DRC_HR_12H] && hr_r[5:0] == `DRC_HR24_MAX
     && min_r == `DRC_MIN_MAX && sec_r == `DRC_SEC_MAX) |=> hr_r == '0)
    else $error("24-hour count did not roll");

  pm_flip_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && tick && hr_r[`DRC_HR_12H] && hr_r[4:0] == `DRC_HR12_PRE
     && min_r == `DRC_MIN_MAX && sec_r == `DRC_SEC_MAX)
    |=> hr_r[`DRC_HR_MODE] != $past(hr_r[`DRC_HR_MODE]) && hr_r[4:0] == `DRC_HR12_MAX)
    else $error("afternoon flag did not change at twelve");

  snap_take_a: assert property (@(posedge clk) disable iff (!arst_n)
    snap_s |=> snap_r[0] == $past(sec_r) && snap_r[4] == $past(date_r))
    else $error("read buffer not refreshed");

  sram_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_evt && wr_addr >= `DRC_ADDR_SRAM) |=> mem_r[$past(wr_addr)] == $past(wr_data))
    else $error("storage byte not written");

  pre_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    sec_write_s |=> pre_cnt_r == '0)
    else $error("divider not restarted by seconds write");

  rst_cal_a: assert property (@(posedge clk)
    $rose(arst_n) |-> date_r == `DRC_RST_DATE && mon_r == `DRC_RST_MON
      && wday_r == `DRC_RST_WDAY && year_r == `DRC_RST_YEAR && hr_r == `DRC_RST_HR)
    else $error("power-up calendar wrong");
endmodule : drc_rtc_top
`default_nettype wire

// file: bench/drc_bus_master.sv
// Two-wire bus master model facing the clock/calendar
`timescale 1ns/1ps
`default_nettype none
module drc_bus_master (
  input  wire logic       clk,
  input  wire logic       sda_w,
  output logic            scl = 1'b1,
  output logic            sda_low = 1'b0,
  output logic [7:0]      rx_byte = 8'h00,
  output logic            rx_stb = 1'b0
);
  // Lines change only with clock low, except start and stop
  task step(input logic l, input logic c);
    sda_low = l;
    scl = c;
    repeat (10) @(negedge clk);
  endtask : step
  // start: data falls while clock high
  task start;
    step(1'b0, 1'b0);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask : start
  // stop: data rises while clock high
  task stop;
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask : stop
  task bit_io(input logic b, output logic v);
    step(!b, 1'b0);
    step(!b, 1'b1);
    v = sda_w;
    step(!b, 1'b0);
  endtask : bit_io
  // address and data bytes, most significant bit first
  task wbyte(input logic [7:0] d, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], v);
    end
    bit_io(1'b1, ack);
  endtask : wbyte
  // acknowledge all but the last byte
  task rbyte(input logic last);
    logic [7:0] d;
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v);
      d[i] = v;
    end
    bit_io(last, v);
    rx_byte = d;
    rx_stb = !rx_stb;
  endtask : rbyte
endmodule : drc_bus_master
`default_nettype wire

// file: bench/test_drc_rtc_top.sv
// Self-checking bench for the clock/calendar block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module test_drc_rtc_top;
  localparam logic [6:0] ADDR = 7'h5a;
  localparam logic [55:0] ST [5] = '{56'h59592307280203, 56'h59592303280204,
    56'h59595102300410, 56'h59592305300421, 56'h59597107310121};
  localparam logic [55:0] EX [5] = '{56'h00000001010303, 56'h00000004290204,
    56'h00007202300410, 56'h00000006010521, 56'h00005201010221};
  logic        clk = 1'b0;
  logic        arst_n;
  logic        ce = 1'b1;
  logic        tbc = 1'b0;
  logic        scl;
  logic        m_low;
  logic        sda_w;
  logic        sda_o;
  logic        sda_oe;
  logic        sqw_o;
  logic        sqw_oe;
  logic [7:0]  rx_byte;
  logic        rx_stb;
  logic        sqw_seen = 1'b0;
  logic        sqw_off = 1'b0;
  logic [7:0]  e_byte;
  logic [7:0]  dat [32];
  logic [7:0]  exq [$];
  int          num_errors = 0;
  int          checked = 0;
  always #25 clk = ~clk;
  assign sda_w = !(m_low || sda_oe === 1'b1);
  drc_rtc_top #(.DIV_32K(16'h4), .DIV_8K(16'h6), .DEV_ADDR(ADDR)) uut (.clk(clk),
    .arst_n(arst_n), .ce(ce), .tb_clk_in(tbc), .scl(scl), .sda_in(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .sqw_o(sqw_o), .sqw_oe(sqw_oe));
  drc_bus_master mst (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_low(m_low),
    .rx_byte(rx_byte), .rx_stb(rx_stb));
  always @(rx_stb) begin
    if ($time > 0) begin
      e_byte = exq.pop_front();
      `CHK(rx_byte, e_byte)
    end
  end
  always @(posedge clk) begin
    if (sqw_oe === 1'b1) begin
      sqw_seen <= 1'b1;
      `CHK(sqw_o, 1'b0)
    end
    if (sqw_seen && sqw_oe === 1'b0) begin
      sqw_off <= 1'b1;
    end
    if (sda_oe === 1'b1) begin
      `CHK(sda_o, 1'b0)
    end
  end
  task end_of_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task put(input logic [7:0] b);
    logic a;
    mst.wbyte(b, a);
    `CHK(a, 1'b0)
  endtask : put
  task wr(input logic [4:0] p, input int n);
    mst.start();
    put({ADDR, 1'b0});
    put({3'h0, p});
    for (int i = 0; i < n; i++) begin
      put(dat[i]);
    end
    mst.stop();
  endtask : wr
  task rd(input logic [4:0] p, input int n);
    mst.start();
    put({ADDR, 1'b0});
    put({3'h0, p});
    mst.start();
    put({ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      mst.rbyte(i == n - 1);
    end
    mst.stop();
  endtask : rd
  task expect_bytes(input logic [119:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      exq.push_back(v[8 * (n - 1 - i) +: 8]);
    end
  endtask : expect_bytes
  // timebase square wave with equal halves
  task tick(input int n);
    repeat (n) begin
      repeat (4) @(negedge clk);
      tbc = 1'b1;
      repeat (4) @(negedge clk);
      tbc = 1'b0;
    end
  endtask : tick
  initial begin
    #4000000;
    num_errors++;
    end_of_test();
  end
  initial begin
    logic a;
    arst_n = 1'b0;
    void'($urandom(32'he721a1b7));
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    expect_bytes(120'h000000010101000000000000000084, 15);
    rd(5'h00, 15);
    $display("test power-up done");
    for (int i = 0; i < 16; i++) begin
      dat[i] = 8'($urandom());
      exq.push_back(dat[i]);
    end
    wr(5'h10, 16);
    expect_bytes(120'h0, 2);
    rd(5'h10, 18);
    $display("test storage done");
    for (int c = 0; c < 5; c++) begin
      for (int i = 0; i < 7; i++) begin
        dat[i] = ST[c][8 * (6 - i) +: 8];
      end
      wr(5'h00, 7);
      tick(4);
      expect_bytes({64'h0, EX[c]}, 7);
      rd(5'h00, 7);
    end
    $display("test calendar done");
    ce = 1'b0;
    tick(4);
    ce = 1'b1;
    expect_bytes(120'h0, 1);
    rd(5'h00, 1);
    $display("test clock enable done");
    dat[0] = 8'ha4;
    wr(5'h0e, 1);
    dat[0] = 8'h00;
    wr(5'h00, 1);
    tick(5);
    expect_bytes(120'h0, 1);
    rd(5'h00, 1);
    tick(1);
    expect_bytes(120'h1, 1);
    rd(5'h00, 1);
    $display("test rate select done");
    `CHK(sqw_seen, 1'b0)
    dat[0] = 8'h80;
    wr(5'h0e, 1);
    tick(8);
    `CHK(sqw_seen, 1'b1)
    `CHK(sqw_off, 1'b1)
    $display("test square wave done");
    mst.start();
    mst.wbyte({ADDR ^ 7'h01, 1'b0}, a);
    `CHK(a, 1'b1)
    mst.stop();
    `CHK(exq.size(), 0)
    $display("test address done");
    end_of_test();
  end
endmodule : test_drc_rtc_top
`default_nettype wire
